// file: bench/charger_protection_sva.sv
// assertion checker bound to the charger protection sequencer
`timescale 1ns/10ps
`default_nettype none
module charger_protection_sva (
	input wire logic clk,
	input wire logic nrst,
	input wire logic supply_input_good,
	input wire logic input_overvoltage,
	input wire logic battery_undervoltage_lockout,
	input wire logic battery_overcurrent,
	input wire logic rail_overvoltage_rising,
	input wire logic temp_shutdown,
	input wire logic ts_hot,
	input wire logic ts_cold,
	input wire logic thermistor_button_pin_low,
	input wire logic battery_switch,
	input wire logic input_switch,
	input wire logic rail_regulation_on,
	input wire logic charge_on,
	input wire logic trickle_on,
	input wire logic factory_mode,
	input wire logic status_out_a_oe,
	input wire logic status_out_b_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence oc_trip;
		battery_overcurrent && battery_switch;
	endsequence
	sequence ts_fault;
		((ts_hot || ts_cold) && supply_input_good)[*3];
	endsequence
	// three samples cover the two-edge latency of latched faults
	chk_ovp_status: assert property ((input_overvoltage && !factory_mode)[*3] |->
		status_out_a_oe && !status_out_b_oe) else $error("ovp status wrong");
	chk_uvlo_open: assert property (battery_undervoltage_lockout[*3] |-> !battery_switch)
		else $error("uvlo switch closed");
	chk_oc_hiccup: assert property (oc_trip |-> ##2 !battery_switch[*8])
		else $error("overcurrent switch not off");
	chk_rail_ovp: assert property (rail_overvoltage_rising[*3] |-> !input_switch)
		else $error("rail ovp switch on");
	chk_tshut_off: assert property (temp_shutdown[*3] |-> !charge_on && !rail_regulation_on)
		else $error("thermal shutdown ignored");
	chk_ts_suspend: assert property (ts_fault |-> !charge_on && !trickle_on)
		else $error("thermistor fault ignored");
	chk_button_hold: assert property ((thermistor_button_pin_low && supply_input_good)[*3]
		|-> !charge_on) else $error("charging with button low");
	chk_charge_code: assert property (charge_on[*2] |-> !status_out_a_oe && status_out_b_oe)
		else $error("charging status wrong");
	chk_factory_quiet: assert property (factory_mode[*2] |-> !battery_switch && !charge_on
		&& !status_out_a_oe && !status_out_b_oe) else $error("factory mode not quiet");
	chk_factory_exit: assert property ($rose(supply_input_good) && factory_mode
		|-> ##[1:2] !factory_mode) else $error("factory mode kept");
endmodule
bind charger_protection_status_fsm charger_protection_sva charger_protection_sva_inst (.*);
`default_nettype wire

// file: bench/status_pullup.sv
// far-side model: pulled-up open-drain status lines as the host reads them
`timescale 1ns/10ps
`default_nettype none
module status_pullup (
	input  wire logic a_oe,
	input  wire logic b_oe,
	output wire logic pin_a,
	output wire logic pin_b
);
	// a released line rests at the pull-up level, never at the last value
	assign pin_a = a_oe ? 1'h0 : 1'h1;
	assign pin_b = b_oe ? 1'h0 : 1'h1;
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// self-checking bench for the charger protection sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk, nrst, sg, ovp, uv, oc, sup, rr, rf, rs, tsd, treg, hot, cold, btn, cen, ssh, pre, term;
	wire logic bsw, isw, rreg, chg, trk, cred, fm, aoe, boe, pa, pb;
	int miscompares, n_compared;
	// short counts keep the run brief; expectations below follow them
	charger_protection_status_fsm #(.LPRESS_TICKS(20), .MAXCHG_TICKS(400), .TICK_CYCLES(2),
		.OC_TICKS(10), .WIN_TICKS(100), .SON_TICKS(5), .SOFF_TICKS(2))
		charger_protection_status_fsm_inst (.clk(clk), .nrst(nrst), .supply_input_good(sg),
		.input_overvoltage(ovp), .battery_undervoltage_lockout(uv), .battery_overcurrent(oc),
		.supplement_active(sup), .rail_overvoltage_rising(rr), .rail_overvoltage_falling(rf),
		.rail_below_short_level(rs), .temp_shutdown(tsd), .temp_regulation(treg), .ts_hot(hot),
		.ts_cold(cold), .thermistor_button_pin_low(btn), .charge_enable_n(cen),
		.set_pin_short(ssh), .battery_precharge(pre), .charge_terminated(term),
		.battery_switch(bsw), .input_switch(isw), .rail_regulation_on(rreg), .charge_on(chg),
		.trickle_on(trk), .charge_current_reduce(cred), .factory_mode(fm),
		.status_out_a_oe(aoe), .status_out_b_oe(boe));
	status_pullup status_pullup_inst (.a_oe(aoe), .b_oe(boe), .pin_a(pa), .pin_b(pb));
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic st(input logic ea, input logic eb);
		chk("pin_a", ea, pa);
		chk("pin_b", eb, pb);
	endtask
	task automatic rst;
		@(negedge clk);
		{sg, ovp, uv, oc, sup, rr, rf, rs, tsd, treg, hot, cold, btn, ssh, pre, term} = '0;
		cen = 1;
		nrst = 0;
		cyc(5);
		nrst = 1;
		cyc(3);
	endtask
	task automatic oc_pulse;
		oc = 1;
		cyc(1);
		oc = 0;
		cyc(1);
	endtask
	task automatic t_ovp;
		rst;
		sg = 1;
		cyc(10);
		ovp = 1;
		cyc(6);
		st(0, 1);
		chk("bsw_ovp", 1, bsw);
		ovp = 0;
		cyc(1);
		st(0, 1);
		cyc(9);
		st(1, 1);
		$display("ovp test done");
	endtask
	task automatic t_oc;
		rst;
		cyc(4);
		chk("bsw_idle", 1, bsw);
		uv = 1;
		cyc(4);
		chk("bsw_uvlo", 0, bsw);
		uv = 0;
		cyc(4);
		oc_pulse;
		chk("bsw_trip", 0, bsw);
		cyc(24);
		chk("bsw_retry", 1, bsw);
		repeat (3) begin
			oc_pulse;
			cyc(26);
		end
		cyc(40);
		chk("bsw_latch", 0, bsw);
		sg = 1;
		cyc(6);
		chk("bsw_vin", 1, bsw);
		sup = 1;
		oc_pulse;
		cyc(40);
		chk("bsw_sup", 0, bsw);
		sup = 0;
		sg = 0;
		cyc(4);
		sg = 1;
		cyc(6);
		chk("bsw_sup_clr", 1, bsw);
		$display("overcurrent test done");
	endtask
	task automatic t_short;
		rst;
		sg = 1;
		rs = 1;
		cyc(6);
		chk("isw_try", 1, isw);
		cyc(164);
		chk("isw_latch", 0, isw);
		chk("bsw_latch", 0, bsw);
		st(0, 1);
		rs = 0;
		sg = 0;
		cyc(4);
		sg = 1;
		cyc(6);
		chk("isw_back", 1, isw);
		rr = 1;
		rf = 1;
		cyc(4);
		chk("isw_rail_ovp", 0, isw);
		rr = 0;
		cyc(4);
		chk("isw_rail_hyst", 0, isw);
		rf = 0;
		cyc(4);
		chk("isw_rail_ok", 1, isw);
		tsd = 1;
		cyc(4);
		chk("rreg_hot", 0, rreg);
		tsd = 0;
		cyc(6);
		chk("rreg_cool", 1, rreg);
		$display("short test done");
	endtask
	task automatic t_charge;
		rst;
		sg = 1;
		cen = 0;
		pre = 1;
		cyc(10);
		chk("chg_on", 1, chg);
		st(1, 0);
		chk("trk_pre", 1, trk);
		treg = 1;
		cyc(4);
		chk("cred", 1, cred);
		treg = 0;
		hot = 1;
		cyc(30);
		chk("chg_hot", 0, chg);
		hot = 0;
		cold = 1;
		cyc(30);
		chk("chg_cold", 0, chg);
		chk("trk_cold", 0, trk);
		st(0, 1);
		cold = 0;
		btn = 1;
		cyc(4);
		chk("chg_btn", 0, chg);
		btn = 0;
		cyc(4);
		chk("chg_rel", 1, chg);
		// the hot spell must not have eaten into the precharge limit
		cyc(150);
		chk("chg_pre_run", 1, chg);
		cyc(60);
		chk("chg_pre_exp", 0, chg);
		st(0, 0);
		cen = 1;
		cyc(2);
		cen = 0;
		cyc(10);
		chk("chg_clear", 1, chg);
		term = 1;
		cyc(4);
		chk("chg_done", 0, chg);
		st(1, 1);
		term = 0;
		pre = 0;
		cyc(700);
		chk("chg_fast_run", 1, chg);
		cyc(140);
		chk("chg_fast_exp", 0, chg);
		$display("charge test done");
	endtask
	task automatic t_factory;
		rst;
		sg = 1;
		btn = 1;
		cyc(30);
		cen = 0;
		cyc(2);
		cen = 1;
		cyc(30);
		sg = 0;
		cyc(4);
		chk("fm_restart", 0, fm);
		sg = 1;
		cyc(50);
		sg = 0;
		cyc(4);
		btn = 0;
		cyc(2);
		chk("fm_in", 1, fm);
		chk("rreg_fm", 0, rreg);
		chk("bsw_fm", 0, bsw);
		st(1, 1);
		btn = 1;
		cyc(4);
		btn = 0;
		cyc(2);
		chk("fm_btn", 1, fm);
		sg = 1;
		cyc(4);
		chk("fm_out", 0, fm);
		$display("factory test done");
	endtask
	task automatic t_setpin;
		rst;
		sg = 1;
		cen = 0;
		cyc(10);
		chk("chg_pre_short", 1, chg);
		ssh = 1;
		cyc(4);
		chk("chg_set_short", 0, chg);
		st(0, 0);
		ssh = 0;
		cyc(4);
		chk("chg_set_held", 0, chg);
		cen = 1;
		cyc(2);
		cen = 0;
		cyc(6);
		chk("chg_set_clear", 1, chg);
		$display("set pin test done");
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	initial begin
		miscompares = 0;
		n_compared = 0;
		nrst = 0;
		cen = 1;
		{sg, ovp, uv, oc, sup, rr, rf, rs, tsd, treg, hot, cold, btn, ssh, pre, term} = '0;
		t_ovp;
		t_oc;
		t_short;
		t_charge;
		t_factory;
		t_setpin;
		tally_and_finish;
	end
	// about 2000 cycles expected; five times that before giving up
	initial begin
		#40000;
		miscompares++;
		tally_and_finish;
	end
endmodule
`default_nettype wire

// file: hdl/charger_protection_consts.vh
// constants for the charger protection and status sequencer
// Functional notes
// - input overvoltage: battery switch on, status low/high
// - status returns to normal only after startup on input power-good
// - battery below lockout level opens battery-to-rail path
// - battery overcurrent: switch off, retry after 250 ms hiccup
// - 4 to 7 consecutive retries in 2 s latch switch off until input
// - hiccup in supplement with input present needs input toggled
// - rail overvoltage opens input switches until below falling level
// - rail overvoltage thresholds 104-106% rising, 101.5-103.5% falling
// - input switch on 5 ms; if rail short, off 200 us then retry
// - short after 10 tries disables both paths until adapter insertion
// - 2 s timer refreshes short retry counter, then checks again
// - thermal shutdown stops charge and rail; auto restart when cooled
// - thermal regulation reduces charge current; battery feeds rail at zero
// - phase safety timers, precharge limit is 25% of maximum time
// - timer fault latch-off, cleared by enable or input toggle
// - long press with input then input removal enters factory mode
// - toggling charge enable with input present restarts long-press timer
// - only valid input insertion leaves factory mode, not the button
// - hot or cold thermistor suspends charging, timers and trickle
// - button press during charging suspends charging until released
// - status encoding: done 11, charging 10, recoverable 01, latch 00
// - per-mode gating of switch, status, sensing, charging and button
// - set-pin short latches fault until input or enable toggled
`ifndef CHARGER_PROTECTION_CONSTS_VH
`define CHARGER_PROTECTION_CONSTS_VH
`define CLK_MHZ            250
`define TICK_US            1
`define TICK_CYCLES        (`CLK_MHZ * `TICK_US)
`define OC_RETRY_MS        250
`define OC_RETRY_TICKS     (`OC_RETRY_MS * 1000 / `TICK_US)
`define WINDOW_S           2
`define WINDOW_TICKS       (`WINDOW_S * 1000000 / `TICK_US)
`define SHORT_ON_MS        5
`define SHORT_ON_TICKS     (`SHORT_ON_MS * 1000 / `TICK_US)
`define SHORT_OFF_US       200
`define SHORT_OFF_TICKS    (`SHORT_OFF_US / `TICK_US)
`define OC_LATCH_TRIES     4
`define SHORT_TRIES        10
`define PRECHG_PERCENT     25
`define LPRESS_TICKS_DEF   2000000
`define MAXCHG_TICKS_DEF   36000000
`endif

// file: hdl/charger_protection_status_fsm.v
// charger protection sequencing, safety timers, factory mode and status pins
`timescale 1ns/10ps
`default_nettype none
`include "charger_protection_consts.vh"
module charger_protection_status_fsm #(
	parameter integer LPRESS_TICKS = `LPRESS_TICKS_DEF,
	parameter integer MAXCHG_TICKS = `MAXCHG_TICKS_DEF,
	parameter integer TICK_CYCLES  = `TICK_CYCLES,
	parameter integer OC_TICKS     = `OC_RETRY_TICKS,
	parameter integer WIN_TICKS    = `WINDOW_TICKS,
	parameter integer SON_TICKS    = `SHORT_ON_TICKS,
	parameter integer SOFF_TICKS   = `SHORT_OFF_TICKS
) (
	input  wire clk,
	input  wire nrst,
	input  wire supply_input_good,
	input  wire input_overvoltage,
	input  wire battery_undervoltage_lockout,
	input  wire battery_overcurrent,
	input  wire supplement_active,
	input  wire rail_overvoltage_rising,
	input  wire rail_overvoltage_falling,
	input  wire rail_below_short_level,
	input  wire temp_shutdown,
	input  wire temp_regulation,
	input  wire ts_hot,
	input  wire ts_cold,
	input  wire thermistor_button_pin_low,
	input  wire charge_enable_n,
	input  wire set_pin_short,
	input  wire battery_precharge,
	input  wire charge_terminated,
	output reg  battery_switch,
	output reg  input_switch,
	output reg  rail_regulation_on,
	output reg  charge_on,
	output reg  trickle_on,
	output reg  charge_current_reduce,
	output reg  factory_mode,
	output reg  status_out_a_oe,
	output reg  status_out_b_oe
);
	localparam integer TW = 32;
	localparam [1:0] SH_CHECK = 2'h0;
	localparam [1:0] SH_OFF   = 2'h1;
	localparam [1:0] SH_WAIT  = 2'h2;
	localparam [1:0] SH_LATCH = 2'h3;

	// countdown on its last count; shared by the hiccup and retry timers
	function last_count;
		input [TW-1:0] cnt;
		begin
			last_count = (cnt <= 32'h0000_0001);
		end
	endfunction

	// shared time base, one pulse per microsecond
	reg  [TW-1:0] div;
	wire          tick = (div == TICK_CYCLES - 1);
	always @(posedge clk) begin
		if (!nrst || tick)
			div <= {TW{1'b0}};
		else
			div <= div + 32'h0000_0001;
	end

	reg  vin_q;
	reg  ce_q;
	wire vin_rise = supply_input_good & ~vin_q;
	wire vin_fall = ~supply_input_good & vin_q;
	wire ce_toggle = charge_enable_n ^ ce_q;
	always @(posedge clk) begin
		if (!nrst) begin
			vin_q <= 1'b0;
			ce_q  <= 1'b1;
		end else begin
			vin_q <= supply_input_good;
			ce_q  <= charge_enable_n;
		end
	end

	// mode: adapter when input good, else battery, or factory
	wire adapter_mode = supply_input_good & ~factory_mode;
	wire batt_mode    = ~supply_input_good & ~factory_mode;

	// startup after overvoltage: wait one tick of power-good
	reg ovp_seen;
	always @(posedge clk) begin
		if (!nrst)
			ovp_seen <= 1'b0;
		else if (input_overvoltage)
			ovp_seen <= 1'b1;
		else if (supply_input_good && tick)
			ovp_seen <= 1'b0;
	end

	// battery overcurrent hiccup
	reg  [TW-1:0] oc_cnt;
	reg  [TW-1:0] oc_win;
	reg  [2:0]    oc_tries;
	reg           oc_off;
	reg           oc_latch;
	reg           oc_supp_latch;
	always @(posedge clk) begin
		if (!nrst) begin
			oc_cnt        <= {TW{1'b0}};
			oc_win        <= {TW{1'b0}};
			oc_tries      <= 3'h0;
			oc_off        <= 1'b0;
			oc_latch      <= 1'b0;
			oc_supp_latch <= 1'b0;
		end else begin
			// a fresh input starts a new detection cycle
			if (vin_rise) begin
				oc_latch <= 1'b0;
				oc_tries <= 3'h0;
			end
			if (vin_fall)
				oc_supp_latch <= 1'b0;
			if (tick && oc_win != 0)
				oc_win <= oc_win - 32'h0000_0001;
			else if (oc_win == 0)
				oc_tries <= 3'h0;
			if (battery_overcurrent && battery_switch) begin
				oc_off <= 1'b1;
				oc_cnt <= OC_TICKS;
				if (oc_win == 0)
					oc_win <= WIN_TICKS;
				oc_tries <= oc_tries + 3'h1;
				if (oc_tries + 3'h1 >= `OC_LATCH_TRIES)
					oc_latch <= 1'b1;
				if (supplement_active && supply_input_good)
					oc_supp_latch <= 1'b1;
			end else if (oc_off && tick) begin
				if (last_count(oc_cnt))
					oc_off <= 1'b0;
				else
					oc_cnt <= oc_cnt - 32'h0000_0001;
			end
		end
	end

	// rail short retry sequencer
	reg  [1:0]    sh_st;
	reg  [TW-1:0] sh_cnt;
	reg  [3:0]    sh_tries;
	reg  [TW-1:0] sh_win;
	always @(posedge clk) begin
		if (!nrst || !supply_input_good) begin
			sh_st    <= SH_CHECK;
			sh_cnt   <= SON_TICKS;
			sh_tries <= 4'h0;
			sh_win   <= WIN_TICKS;
		end else begin
			if (tick && sh_win != 0)
				sh_win <= sh_win - 32'h0000_0001;
			else if (sh_win == 0 && sh_st != SH_LATCH) begin
				sh_tries <= 4'h0;
				sh_win   <= WIN_TICKS;
			end
			case (sh_st)
			SH_CHECK: begin
				if (tick) begin
					if (last_count(sh_cnt)) begin
						if (rail_below_short_level) begin
							if (sh_tries + 4'h1 >= `SHORT_TRIES)
								sh_st <= SH_LATCH;
							else
								sh_st <= SH_OFF;
							sh_tries <= sh_tries + 4'h1;
							sh_cnt   <= SOFF_TICKS;
						end else begin
							sh_st <= SH_WAIT;
						end
					end else begin
						sh_cnt <= sh_cnt - 32'h0000_0001;
					end
				end
			end
			SH_OFF: begin
				if (tick) begin
					if (last_count(sh_cnt)) begin
						sh_st  <= SH_CHECK;
						sh_cnt <= SON_TICKS;
					end else begin
						sh_cnt <= sh_cnt - 32'h0000_0001;
					end
				end
			end
			SH_WAIT: begin
				// rail up; re-check once the 2 s window expires
				if (sh_win == 0) begin
					sh_st  <= SH_CHECK;
					sh_cnt <= SON_TICKS;
				end
			end
			SH_LATCH: begin
				// held while the input stays good; input removal returns to SH_CHECK
				sh_st <= SH_LATCH;
			end
			default: sh_st <= SH_CHECK;
			endcase
		end
	end
	wire short_recov = (sh_st == SH_OFF) || (sh_st == SH_CHECK && sh_tries != 0);
	wire short_latch = (sh_st == SH_LATCH);

	// rail overvoltage with hysteresis, thresholds from the comparators
	reg rail_ovp;
	always @(posedge clk) begin
		if (!nrst)
			rail_ovp <= 1'b0;
		else if (rail_overvoltage_rising)
			rail_ovp <= 1'b1;
		else if (!rail_overvoltage_falling)
			rail_ovp <= 1'b0;
	end

	// thermal shutdown; power-up hot blocks until cooled
	reg tshut;
	// resets hot so no switch closes before the first sample, except the battery switch under input overvoltage
	always @(posedge clk) begin
		if (!nrst)
			tshut <= 1'b1;
		else
			tshut <= temp_shutdown;
	end

	// set-pin short latch
	reg charge_current_set_pin_fault;
	// clear beats set: the toggle itself re-arms detection
	always @(posedge clk) begin
		if (!nrst || vin_rise || vin_fall || ce_toggle)
			charge_current_set_pin_fault <= 1'b0;
		else if (set_pin_short && supply_input_good && !charge_enable_n)
			charge_current_set_pin_fault <= 1'b1;
	end

	// safety timers
	// count holds while charging is not requested
	wire          ts_fault = ts_hot | ts_cold;
	reg  [TW-1:0] sft_cnt;
	reg           sft_pre;
	reg           sft_fault;
	wire          charging_req = adapter_mode & ~charge_enable_n & ~charge_terminated;
	wire [TW-1:0] pre_limit = (MAXCHG_TICKS / 100) * `PRECHG_PERCENT;
	always @(posedge clk) begin
		if (!nrst || vin_rise || vin_fall || ce_toggle) begin
			sft_cnt   <= {TW{1'b0}};
			sft_pre   <= 1'b1;
			sft_fault <= 1'b0;
		end else if (charging_req && !sft_fault) begin
			if (sft_pre != battery_precharge) begin
				sft_pre <= battery_precharge;
				sft_cnt <= {TW{1'b0}};
			end else if (tick && !ts_fault) begin
				sft_cnt <= sft_cnt + 32'h0000_0001;
				if (sft_pre ? (sft_cnt >= pre_limit) : (sft_cnt >= MAXCHG_TICKS))
					sft_fault <= 1'b1;
			end
		end
	end

	// long press and factory mode
	reg  [TW-1:0] lp_cnt;
	reg           lp_done;
	// count holds while the input is away
	always @(posedge clk) begin
		if (!nrst) begin
			lp_cnt       <= {TW{1'b0}};
			lp_done      <= 1'b0;
			factory_mode <= 1'b0;
		end else begin
			if (supply_input_good && ce_toggle) begin
				lp_cnt  <= {TW{1'b0}};
				lp_done <= 1'b0;
			end else if (supply_input_good && thermistor_button_pin_low && !factory_mode) begin
				if (tick && lp_cnt < LPRESS_TICKS)
					lp_cnt <= lp_cnt + 32'h0000_0001;
				if (lp_cnt >= LPRESS_TICKS)
					lp_done <= 1'b1;
			end else if (supply_input_good) begin
				lp_cnt <= {TW{1'b0}};
			end
			if (vin_fall && lp_done) begin
				factory_mode <= 1'b1;
				lp_done      <= 1'b0;
			end else if (vin_rise) begin
				factory_mode <= 1'b0;
			end
		end
	end

	// switch, charge and status outputs
	// system short reports recoverable while its paths stay latched
	wire latch_fault = oc_latch | oc_supp_latch | sft_fault | charge_current_set_pin_fault;
	wire recov_fault = input_overvoltage | ovp_seen | tshut | short_recov | short_latch
		| (adapter_mode & ts_fault);
	wire chg = charging_req & ~sft_fault & ~charge_current_set_pin_fault & ~tshut & ~input_overvoltage;
	always @(posedge clk) begin
		if (!nrst) begin
			battery_switch        <= 1'b0;
			input_switch          <= 1'b0;
			rail_regulation_on    <= 1'b0;
			charge_on             <= 1'b0;
			trickle_on            <= 1'b0;
			charge_current_reduce <= 1'b0;
			status_out_a_oe       <= 1'b0;
			status_out_b_oe       <= 1'b0;
		end else begin
			// input overvoltage keeps the battery on the rail; lockout still wins
			battery_switch <= ~factory_mode & ~tshut & ~battery_undervoltage_lockout
				& ~oc_off & ~oc_latch & ~oc_supp_latch & ~short_latch
				| (input_overvoltage & ~factory_mode & ~battery_undervoltage_lockout);
			input_switch <= adapter_mode & ~input_overvoltage & ~tshut & ~rail_ovp
				& (sh_st != SH_OFF) & ~short_latch;
			rail_regulation_on <= ~factory_mode & ~tshut;
			// thermistor and button only count in adapter mode
			charge_on  <= chg & ~ts_fault & ~thermistor_button_pin_low;
			trickle_on <= chg & ~ts_fault & battery_precharge;
			charge_current_reduce <= chg & temp_regulation;
			// oe high pulls the pin low; factory mode leaves both released
			if (factory_mode) begin
				status_out_a_oe <= 1'b0;
				status_out_b_oe <= 1'b0;
			end else if (latch_fault) begin
				status_out_a_oe <= 1'b1;
				status_out_b_oe <= 1'b1;
			end else if (recov_fault) begin
				status_out_a_oe <= 1'b1;
				status_out_b_oe <= 1'b0;
			end else if (chg) begin
				status_out_a_oe <= 1'b0;
				status_out_b_oe <= 1'b1;
			end else begin
				status_out_a_oe <= 1'b0;
				status_out_b_oe <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire
